// ---- hdl/nvmac_ctrl.sv ----
/*
  EEPROM access controller: address, data and control registers, read
  fetch, timed erase/write, unlock window, CPU stall and interrupts.
  Assumes a combinational-read EEPROM array and a synchronous CPU bus.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
// Behaviour
// RULE_01: Twelve-bit linear address over two byte registers.
// RULE_02: Unused address-high and control top bits read zero.
// RULE_03: Data register sources writes, receives read bytes.
// RULE_04: Mode decode: atomic, erase, write, reserved timings.
// RULE_05: Mode writes ignored while programming strobe set.
// RULE_06: Reset clears mode unless programming in progress.
// RULE_07: Ready interrupt while enabled and strobe clear.
// RULE_08: Master enable clears itself four cycles later.
// RULE_09: Strobe starts programming only with master enable.
// RULE_10: Software unlock sequence timing is its duty.
// RULE_11: No programming while flash self-programming busy.
// RULE_12: Strobe clears when programming time elapses.
// RULE_13: Programming strobe stalls CPU two cycles.
// RULE_14: Read fetches immediately, stalls CPU four cycles.
// RULE_15: Busy refuses reads and address changes.
// RULE_16: Software keeps interrupts off during unlock.
// RULE_17: Software writes address before first access.
// RULE_18: Read strobe clears after data loads.
module nvmac_ctrl #(
  parameter int ATOMIC_CYC = nvmac_pkg::ATOMIC_CYCLES,
  parameter int SINGLE_CYC = nvmac_pkg::SINGLE_CYCLES
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [7:0]                    reg_rdata,
  input  wire logic                     global_irq_en,
  input  wire logic                     self_prog_busy,
  output nvmac_pkg::nvmac_mem_req_s     mem_req,
  input  wire logic [7:0]               mem_rdata,
  output logic                          cpu_stall,
  output logic                          ready_irq,
  output logic                          irq
);
  import nvmac_pkg::*;

  // Refuse counts that the 24-bit timer cannot hold
  if (ATOMIC_CYC < 2 || SINGLE_CYC < 2 || ATOMIC_CYC >= (1 << 24) || SINGLE_CYC >= (1 << 24))
  begin : g_bad_cycles
    $error("nvmac_ctrl: programming cycle counts out of range");
  end

  // ----------------------------------------------------------------------
  // Programming state
  // ----------------------------------------------------------------------
  typedef enum {NVMAC_IDLE, NVMAC_PROG} nvmac_state_e;

  nvmac_state_e   state_q, state_d;
  logic [23:0]    timer_q, timer_d;
  logic [11:0]    addr_q, addr_d;
  logic [7:0]     data_q, data_d;
  logic [1:0]     mode_q, mode_d;
  logic           rie_q, rie_d;
  logic           mpe_q, mpe_d;
  logic [2:0]     mpe_cnt_q, mpe_cnt_d;
  logic           pe_q, pe_d;
  logic [2:0]     stall_q, stall_d;
  logic [2:0]     stat_q, stat_d;
  logic [2:0]     mask_q, mask_d;
  logic [7:0]     rdata_q, rdata_d;
  logic           rd_pulse_q, rd_pulse_d;
  logic           erase_q, erase_d, write_q, write_d;

  logic wr_ctl, wr_data, wr_alo, wr_ahi, wr_stat, wr_mask;
  logic set_pe, set_re, start_prog, do_read, refuse, done;

  // Programming time for a mode, in cycles
  function automatic logic [23:0] prog_time(input logic [1:0] m);
    unique case (nvmac_mode_e'(m))
      NVMAC_MODE_ATOMIC: prog_time = 24'(ATOMIC_CYC);               // RULE_04
      NVMAC_MODE_ERASE,
      NVMAC_MODE_WRITE:  prog_time = 24'(SINGLE_CYC);               // RULE_04
      NVMAC_MODE_RSVD:   prog_time = 24'h000000;
    endcase
  endfunction

  // Register write decode
  always_comb
  begin
    wr_ctl  = reg_wr && reg_addr == NVM_CONTROL_OFS;
    wr_data = reg_wr && reg_addr == NVM_DATA_OFS;
    wr_alo  = reg_wr && reg_addr == NVM_ADDR_LO_OFS;
    wr_ahi  = reg_wr && reg_addr == NVM_ADDR_HI_OFS;
    wr_stat = reg_wr && reg_addr == NVM_IRQ_STAT_OFS;
    wr_mask = reg_wr && reg_addr == NVM_IRQ_MASK_OFS;
    set_pe  = wr_ctl && reg_wdata[CTL_PROG_STROBE];
    set_re  = wr_ctl && reg_wdata[CTL_READ_STROBE];
    // Start only inside the unlock window, idle, flash not busy, legal mode
    start_prog = set_pe && mpe_q && !pe_q && !self_prog_busy        // RULE_09 RULE_11
                 && mode_q != NVMAC_MODE_RSVD;
    do_read    = set_re && !pe_q && !set_pe;                         // RULE_15
    refuse     = (set_re && pe_q) || (set_pe && mpe_q && self_prog_busy);
    done       = state_q == NVMAC_PROG && timer_q == 24'h000001;
  end

  // Next-state logic for registers and programming sequencer
  always_comb
  begin
    state_d    = state_q;
    timer_d    = timer_q;
    addr_d     = addr_q;
    data_d     = data_q;
    mode_d     = mode_q;
    rie_d      = rie_q;
    mpe_d      = mpe_q;
    mpe_cnt_d  = mpe_cnt_q;
    pe_d       = pe_q;
    stall_d    = (stall_q != 3'h0) ? stall_q - 3'h1 : 3'h0;
    stat_d     = stat_q;
    mask_d     = mask_q;
    rd_pulse_d = do_read;
    erase_d    = 1'b0;
    write_d    = 1'b0;
    // Address frozen while programming
    if (!pe_q)                                                      // RULE_15
    begin
      if (wr_alo)
        addr_d[7:0] = reg_wdata;                                    // RULE_01
      if (wr_ahi)
        addr_d[11:8] = reg_wdata[3:0];                              // RULE_01
    end
    if (wr_data)
      data_d = reg_wdata;
    if (do_read)
    begin
      data_d  = mem_rdata;                                          // RULE_03 RULE_14
      stall_d = 3'(READ_STALL_CYC);                                 // RULE_14
    end
    if (wr_ctl)
    begin
      rie_d = reg_wdata[CTL_READY_IRQ_EN];
      if (!pe_q)
        mode_d = reg_wdata[CTL_MODE_HI:CTL_MODE_LO];                // RULE_05
      if (reg_wdata[CTL_MASTER_EN] && !reg_wdata[CTL_PROG_STROBE])
      begin
        mpe_d     = 1'b1;
        mpe_cnt_d = 3'(MASTER_EN_CYC);
      end
    end
    // Unlock window countdown
    if (mpe_q && !(wr_ctl && reg_wdata[CTL_MASTER_EN] && !reg_wdata[CTL_PROG_STROBE]))
    begin
      mpe_cnt_d = mpe_cnt_q - 3'h1;
      if (mpe_cnt_q == 3'h1)
        mpe_d = 1'b0;                                               // RULE_08
    end
    // Never shorten a longer stall still running from a read
    if (set_pe && stall_d < 3'(PROG_STALL_CYC))
      stall_d = 3'(PROG_STALL_CYC);                                 // RULE_13
    unique case (state_q)
      NVMAC_IDLE:
        if (start_prog)
        begin
          state_d = NVMAC_PROG;
          pe_d    = 1'b1;
          timer_d = prog_time(mode_q);                              // RULE_04
          erase_d = mode_q != NVMAC_MODE_WRITE;
          write_d = mode_q != NVMAC_MODE_ERASE;
        end
      NVMAC_PROG:
      begin
        timer_d = timer_q - 24'h000001;
        if (done)
        begin
          state_d = NVMAC_IDLE;
          pe_d    = 1'b0;                                           // RULE_12
        end
      end
    endcase
    // Sticky status, set wins over write-one-clear
    if (wr_stat)
      stat_d = stat_q & ~reg_wdata[2:0];
    if (done)
      stat_d[IRQ_PROG_DONE] = 1'b1;
    if (rd_pulse_q)
      stat_d[IRQ_READ_DONE] = 1'b1;
    if (refuse)
      stat_d[IRQ_REFUSED] = 1'b1;
    if (wr_mask)
      mask_d = reg_wdata[2:0];
  end

  // Register read mux, data one cycle after strobe
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        NVM_CONTROL_OFS:  rdata_d = {2'b00, mode_q, rie_q, mpe_q, pe_q, 1'b0}; // RULE_02 RULE_18
        NVM_DATA_OFS:     rdata_d = data_q;
        NVM_ADDR_LO_OFS:  rdata_d = addr_q[7:0];
        NVM_ADDR_HI_OFS:  rdata_d = {4'h0, addr_q[11:8]};                    // RULE_02
        NVM_IRQ_STAT_OFS: rdata_d = {5'h00, stat_q};
        NVM_IRQ_MASK_OFS: rdata_d = {5'h00, mask_q};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // Registers; mode survives reset while programming is in progress
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q    <= NVMAC_IDLE;
      timer_q    <= 24'h000000;
      addr_q     <= 12'h000;
      data_q     <= DATA_RESET;
      rie_q      <= 1'b0;
      mpe_q      <= 1'b0;
      mpe_cnt_q  <= 3'h0;
      pe_q       <= 1'b0;
      stall_q    <= 3'h0;
      stat_q     <= 3'h0;
      mask_q     <= MASK_RESET;
      rdata_q    <= 8'h00;
      rd_pulse_q <= 1'b0;
      erase_q    <= 1'b0;
      write_q    <= 1'b0;
      if (!pe_q)
        mode_q <= MODE_RESET;                                       // RULE_06
    end
    else
    begin
      state_q    <= state_d;
      timer_q    <= timer_d;
      addr_q     <= addr_d;
      data_q     <= data_d;
      mode_q     <= mode_d;
      rie_q      <= rie_d;
      mpe_q      <= mpe_d;
      mpe_cnt_q  <= mpe_cnt_d;
      pe_q       <= pe_d;
      stall_q    <= stall_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      rdata_q    <= rdata_d;
      rd_pulse_q <= rd_pulse_d;
      erase_q    <= erase_d;
      write_q    <= write_d;
    end
  end

  // Outputs
  always_comb
  begin
    reg_rdata     = rdata_q;
    mem_req.rd    = do_read;
    mem_req.erase = erase_q;
    mem_req.write = write_q;
    mem_req.addr  = addr_q;
    mem_req.wdata = data_q;                                         // RULE_03
    cpu_stall     = stall_q != 3'h0;
    ready_irq     = rie_q && global_irq_en && !pe_q;                // RULE_07
    irq           = |(stat_q & mask_q);
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_master_en_timeout; // RULE_08
    @(posedge mclk) disable iff (!rst_n)
      $rose(mpe_q) ##0 (!(wr_ctl && reg_wdata[CTL_MASTER_EN] && !reg_wdata[CTL_PROG_STROBE])) [*4]
        |=> !mpe_q;
  endproperty
  a_master_en_timeout: assert property (p_master_en_timeout) // RULE_08
    else $error("master enable did not clear after four cycles");

  property p_no_start_without_mpe; // RULE_09
    @(posedge mclk) disable iff (!rst_n)
      set_pe && !mpe_q && !pe_q |=> !pe_q;
  endproperty
  a_no_start_without_mpe: assert property (p_no_start_without_mpe) // RULE_09
    else $error("programming started without master enable");

  property p_no_start_flash_busy; // RULE_11
    @(posedge mclk) disable iff (!rst_n)
      self_prog_busy && !pe_q |=> !pe_q;
  endproperty
  a_no_start_flash_busy: assert property (p_no_start_flash_busy) // RULE_11
    else $error("programming started during flash programming");

  property p_mode_locked; // RULE_05
    @(posedge mclk) disable iff (!rst_n)
      pe_q && pe_d |=> $stable(mode_q);
  endproperty
  a_mode_locked: assert property (p_mode_locked) // RULE_05
    else $error("mode changed while programming");

  property p_addr_locked; // RULE_15
    @(posedge mclk) disable iff (!rst_n)
      pe_q |=> $stable(addr_q);
  endproperty
  a_addr_locked: assert property (p_addr_locked) // RULE_15
    else $error("address changed while programming");

  property p_read_fetch; // RULE_14
    @(posedge mclk) disable iff (!rst_n)
      do_read |=> (data_q == $past(mem_rdata)) ##0 cpu_stall [*4];
  endproperty
  a_read_fetch: assert property (p_read_fetch) // RULE_14
    else $error("read did not load data or stall four cycles");

  property p_prog_stall; // RULE_13
    @(posedge mclk) disable iff (!rst_n)
      set_pe && !set_re |=> cpu_stall [*2];
  endproperty
  a_prog_stall: assert property (p_prog_stall) // RULE_13
    else $error("programming strobe did not stall two cycles");

  property p_ready_irq; // RULE_07
    @(posedge mclk) disable iff (!rst_n)
      ready_irq |-> rie_q && global_irq_en && !pe_q;
  endproperty
  a_ready_irq: assert property (p_ready_irq) // RULE_07
    else $error("ready interrupt wrong");

  property p_strobe_clears; // RULE_12
    @(posedge mclk) disable iff (!rst_n)
      done |=> !pe_q && stat_q[IRQ_PROG_DONE];
  endproperty
  a_strobe_clears: assert property (p_strobe_clears) // RULE_12
    else $error("strobe not cleared at end of programming");

  property p_read_stall_end; // RULE_14
    @(posedge mclk) disable iff (!rst_n)
      do_read ##1 (!set_pe && !do_read) [*4] |=> !cpu_stall;
  endproperty
  a_read_stall_end: assert property (p_read_stall_end) // RULE_14
    else $error("read stall lasted beyond four cycles");

  property p_mode_reset_clear; // RULE_06
    @(posedge mclk)
      !rst_n && !pe_q |=> mode_q == MODE_RESET;
  endproperty
  a_mode_reset_clear: assert property (p_mode_reset_clear) // RULE_06
    else $error("mode not cleared by reset while idle");

  property p_mode_reset_keep; // RULE_06
    @(posedge mclk)
      !rst_n && pe_q |=> $stable(mode_q);
  endproperty
  a_mode_reset_keep: assert property (p_mode_reset_keep) // RULE_06
    else $error("mode lost by reset during programming");

  property p_ctl_read_zero; // RULE_02 RULE_18
    @(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == NVM_CONTROL_OFS
        |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[CTL_READ_STROBE];
  endproperty
  a_ctl_read_zero: assert property (p_ctl_read_zero) // RULE_02 RULE_18
    else $error("control readback shows nonzero reserved or read bits");

  property p_atomic_start; // RULE_04
    @(posedge mclk) disable iff (!rst_n)
      start_prog && mode_q == NVMAC_MODE_ATOMIC
        |=> pe_q && mem_req.erase && mem_req.write && timer_q == 24'(ATOMIC_CYC);
  endproperty
  a_atomic_start: assert property (p_atomic_start) // RULE_04
    else $error("atomic programming did not start as erase plus write");

  property p_read_refused; // RULE_15
    @(posedge mclk) disable iff (!rst_n)
      set_re && pe_q |-> !mem_req.rd ##1 stat_q[IRQ_REFUSED];
  endproperty
  a_read_refused: assert property (p_read_refused) // RULE_15
    else $error("read during programming was not refused");

endmodule // nvmac_ctrl

// ---- shared/nvmac_pkg.sv ----
/*
  Package for the EEPROM access controller: register offsets, control bit
  positions, programming modes, timing constants and the EEPROM port struct.
  Assumes a single 125 MHz clock shared with the CPU.
*/
package nvmac_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte offsets on the strobed register port)
  // ----------------------------------------------------------------------
  localparam logic [7:0] NVM_CONTROL_OFS  = 8'h1F;
  localparam logic [7:0] NVM_DATA_OFS     = 8'h20;
  localparam logic [7:0] NVM_ADDR_LO_OFS  = 8'h21;
  localparam logic [7:0] NVM_ADDR_HI_OFS  = 8'h22;
  localparam logic [7:0] NVM_IRQ_STAT_OFS = 8'h23;
  localparam logic [7:0] NVM_IRQ_MASK_OFS = 8'h24;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTL_READ_STROBE  = 0;
  localparam int CTL_PROG_STROBE  = 1;
  localparam int CTL_MASTER_EN    = 2;
  localparam int CTL_READY_IRQ_EN = 3;
  localparam int CTL_MODE_LO      = 4;
  localparam int CTL_MODE_HI      = 5;

  // Interrupt status / mask fields
  localparam int IRQ_PROG_DONE = 0;
  localparam int IRQ_READ_DONE = 1;
  localparam int IRQ_REFUSED   = 2;

  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ         = 125;
  localparam int T_ATOMIC_US     = 3400;
  localparam int T_SINGLE_US     = 1800;
  localparam int ATOMIC_CYCLES   = T_ATOMIC_US * CLK_MHZ;
  localparam int SINGLE_CYCLES   = T_SINGLE_US * CLK_MHZ;
  localparam int MASTER_EN_CYC   = 4;
  localparam int PROG_STALL_CYC  = 2;
  localparam int READ_STALL_CYC  = 4;

  // Programming modes
  typedef enum logic [1:0] {
    NVMAC_MODE_ATOMIC = 2'h0,
    NVMAC_MODE_ERASE  = 2'h1,
    NVMAC_MODE_WRITE  = 2'h2,
    NVMAC_MODE_RSVD   = 2'h3
  } nvmac_mode_e;

  // Request to the EEPROM array
  typedef struct packed {
    logic        rd;
    logic        erase;
    logic        write;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } nvmac_mem_req_s;

endpackage

// ---- dv/nvmac_mem_model.sv ----
/*
  Behavioural EEPROM array that sits behind the access controller.
  Assumes one-cycle erase/write pulses and a combinational read.
*/
`timescale 1ns/100ps
module nvmac_mem_model (
  input  wire logic                     mclk,
  input  wire nvmac_pkg::nvmac_mem_req_s mem_req,
  output logic [7:0]                    mem_rdata
);
  import nvmac_pkg::*;
  logic [7:0] mem [4096];
  logic [7:0] junk_q;
  // Array starts erased
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hFF;
    junk_q = 8'h00;
  end
  // Erase sets ones, write alone can only clear bits
  always @(posedge mclk)
  begin
    junk_q <= junk_q + 8'h3B;
    if (mem_req.erase && mem_req.write) mem[mem_req.addr] <= mem_req.wdata;
    else if (mem_req.erase) mem[mem_req.addr] <= 8'hFF;
    else if (mem_req.write) mem[mem_req.addr] <= mem[mem_req.addr] & mem_req.wdata;
  end
  // Data only while asked, shifting junk otherwise
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : junk_q;
endmodule // nvmac_mem_model

// ---- dv/tb_top.sv ----
/*
  Self-checking bench for the EEPROM access controller.
  Assumes the array model in nvmac_mem_model and short programming times.
*/
`timescale 1ns/100ps
module tb_top;
  import nvmac_pkg::*;
  localparam int AT = 30;
  localparam int SG = 16;
  logic           mclk, rst_n, reg_wr, reg_rd, gie, spb, rdy, irq, stall;
  logic [7:0]     reg_addr, reg_wdata, reg_rdata, mem_rdata;
  nvmac_mem_req_s mem_req;
  int             n_errors, checks, cyc, stall_n, n;
  logic [7:0]     rows [6][3] = '{'{NVM_ADDR_HI_OFS, 8'hFF, 8'h0F},
    '{NVM_ADDR_LO_OFS, 8'hA5, 8'hA5}, '{NVM_DATA_OFS, 8'h3C, 8'h3C},
    '{NVM_CONTROL_OFS, 8'hC8, 8'h08}, '{8'h30, 8'h55, 8'h00},
    '{NVM_IRQ_MASK_OFS, 8'hFF, 8'h07}};

  nvmac_ctrl #(.ATOMIC_CYC(AT), .SINGLE_CYC(SG)) DUT (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .global_irq_en(gie), .self_prog_busy(spb),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .cpu_stall(stall),
    .ready_irq(rdy), .irq(irq));
  nvmac_mem_model u_mem (.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------------
  // Clock, stall counter and hang guard
  // ----------------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Counted on the falling edge, clear of the register updates
  always @(negedge mclk)
  begin
    cyc++;
    if (stall) stall_n++;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Bus tasks and compare
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    @(posedge mclk);
  endtask
  // Unlock then strobe two cycles later, with interrupts held off
  task automatic prog(input logic [7:0] c);
    gie <= 1'b0;
    wr(NVM_CONTROL_OFS, c);
    wr(NVM_CONTROL_OFS, c | 8'h02);
    gie <= 1'b1;
    @(posedge mclk);
  endtask
  // Cycles until the ready line comes back, looked at clear of the edge
  task automatic busy();
    n = 0;
    while (rdy !== 1'b1 && n < 1000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
  endtask
  task automatic end_sim();
    $display("n_errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    gie = 1'b1;
    spb = 1'b0;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    stall_n = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rchk(NVM_DATA_OFS, 8'h00);
    rchk(NVM_CONTROL_OFS, 8'h00);
    // Address set before any access
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i][0], rows[i][1]);
      rchk(rows[i][0], rows[i][2]);
    end
    chk({7'h0, rdy}, 8'h01);
    // Write-only to 0xFA5, then read back
    wr(NVM_DATA_OFS, 8'h5A);
    stall_n = 0;
    prog(8'h2C);
    chk({7'h0, rdy}, 8'h00);
    busy();
    chk(8'(n >= SG - 3 && n <= SG + 1), 8'h01);
    chk(8'(stall_n), 8'h02);
    stall_n = 0;
    wr(NVM_CONTROL_OFS, 8'h09);
    repeat (4) @(posedge mclk);
    chk(8'(stall_n), 8'h04);
    rchk(NVM_DATA_OFS, 8'h5A);
    rchk(NVM_CONTROL_OFS, 8'h08);
    // Atomic then erase-only at the same place
    wr(NVM_DATA_OFS, 8'h11);
    prog(8'h0C);
    busy();
    chk(8'(n >= AT - 3 && n <= AT + 1), 8'h01);
    wr(NVM_CONTROL_OFS, 8'h09);
    rchk(NVM_DATA_OFS, 8'h11);
    prog(8'h1C);
    busy();
    chk(8'(n >= SG - 3 && n <= SG + 1), 8'h01);
    wr(NVM_CONTROL_OFS, 8'h09);
    rchk(NVM_DATA_OFS, 8'hFF);
    // Reserved mode never starts
    prog(8'h3C);
    chk({7'h0, rdy}, 8'h01);
    repeat (6) @(posedge mclk);
    rchk(NVM_CONTROL_OFS, 8'h38);
    // Strobe after the unlock window has closed
    wr(NVM_CONTROL_OFS, 8'h0C);
    repeat (5) @(posedge mclk);
    wr(NVM_CONTROL_OFS, 8'h0A);
    rchk(NVM_CONTROL_OFS, 8'h08);
    // Flash self-programming blocks the start
    spb <= 1'b1;
    prog(8'h0C);
    repeat (6) @(posedge mclk);
    rchk(NVM_CONTROL_OFS, 8'h08);
    spb <= 1'b0;
    // Refusals while programming
    prog(8'h2C);
    wr(NVM_ADDR_LO_OFS, 8'h00);
    wr(NVM_CONTROL_OFS, 8'h1A);
    rchk(NVM_CONTROL_OFS, 8'h2A);
    wr(NVM_CONTROL_OFS, 8'h09);
    rchk(NVM_ADDR_LO_OFS, 8'hA5);
    busy();
    rchk(NVM_IRQ_STAT_OFS, 8'h07);
    chk({7'h0, irq}, 8'h01);
    wr(NVM_IRQ_STAT_OFS, 8'h07);
    chk({7'h0, irq}, 8'h00);
    rchk(NVM_IRQ_STAT_OFS, 8'h00);
    wr(NVM_IRQ_MASK_OFS, 8'h00);
    wr(NVM_CONTROL_OFS, 8'h09);
    chk({7'h0, irq}, 8'h00);
    rchk(NVM_IRQ_STAT_OFS, 8'h02);
    // Reset in mid-programming keeps the mode
    prog(8'h1C);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rchk(NVM_CONTROL_OFS, 8'h10);
    rchk(NVM_DATA_OFS, 8'h00);
    end_sim();
  end
endmodule // tb_top
